/* File: rtl/fnvwp_ctrl.sv */
// fnvwp_ctrl: self-write controller and write guard for the nonvolatile arrays
`timescale 1ns/10ps
`default_nettype none
// Operation
// - flash store needs permit fuse, unguarded word
// - store needs 55h then AAh just before go
// - flash store stalls two instruction slots
// - stall is no sleep, clocks keep running
// - resume at third instruction after go
// - power-up clears the store permit bit
// - power-up lockout blocks data stores
// - permit fuse zero refuses all flash stores
// - user code cannot change fuses
// - any code guard shuts programmer out
// - core data access ignores data guard
// - data guard blocks programmer flash access
// - internal flash reads always allowed
// - guard pair sets programmer access level
// - fuses clear only by full erase
// - completion clears go, sets done flag
// - go needs permit set beforehand
// - software sets go bits, hardware clears
// - reset during store sets abort flag (a power-up reset clears it instead)
module fnvwp_ctrl #(
	parameter int unsigned PWRT_CYC = fnvwp_pkg::PWRT_CYC_DEF, // lockout cycles
	parameter int unsigned FL_CYC   = fnvwp_pkg::FL_CYC_DEF,   // flash stall cycles
	parameter int unsigned EE_CYC   = fnvwp_pkg::EE_CYC_DEF,   // data store cycles
	parameter logic [fnvwp_pkg::ADDR_W-1:0] PROT_BASE = fnvwp_pkg::PROT_BASE_DEF
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic                         por_rst,
	input  wire fnvwp_pkg::fnvwp_bus_type     bus_req,
	output logic [7:0]                        bus_rdata,
	output logic                              core_stall,
	output logic                              core_skip,
	output logic                              store_done_irq,
	output logic [fnvwp_pkg::ADDR_W-1:0]      arr_addr,
	output logic [fnvwp_pkg::WORD_W-1:0]      arr_wdata,
	output logic                              ee_store_go,
	output logic                              fl_store_go,
	input  wire logic [7:0]                   ee_rdata,
	input  wire logic [fnvwp_pkg::WORD_W-1:0] fl_rdata,
	input  wire fnvwp_pkg::fnvwp_cfg_type     cfg_nv,
	input  wire logic                         prog_load,
	input  wire fnvwp_pkg::fnvwp_cfg_type     prog_word,
	input  wire logic                         prog_erase,
	output logic                              ext_read_ok,
	output logic                              ext_write_ok
);
	import fnvwp_pkg::*;

	// counter reload values and the lockout end count
	localparam logic [CNT_W-1:0] FL_LAST = CNT_W'(FL_CYC - 1);
	localparam logic [CNT_W-1:0] EE_LAST = CNT_W'(EE_CYC - 1);
	localparam logic [CNT_W-1:0] RF_LAST = CNT_W'(RD_FL_CYC - 1);
	localparam logic [CNT_W-1:0] PW_END  = CNT_W'(PWRT_CYC);

	fnvwp_op_type       op_ff;     // operation in progress
	fnvwp_op_type       nxt_op;    // next operation
	logic [CNT_W-1:0]   cnt_ff;    // cycles left in operation
	logic [CNT_W-1:0]   nxt_cnt;   // next count
	logic [CNT_W-1:0]   pwrt_ff;   // power-up lockout count
	logic [7:0]         alo_ff;    // address low byte
	logic [AHI_W-1:0]   ahi_ff;    // address high bits
	logic [7:0]         dlo_ff;    // data low byte
	logic [DHI_W-1:0]   dhi_ff;    // data high bits
	logic               memsel_ff; // one selects flash
	logic               permit_ff; // store permit bit
	logic               abort_ff;  // store cut by reset
	logic               done_ff;   // store done flag
	logic               dmask_ff;  // store done mask
	logic               gmask_ff;  // global mask
	logic               pmask_ff;  // peripheral mask
	logic [7:0]         rdata_ff;  // read answer
	logic               ee_go_ff;  // data store strobe
	logic               fl_go_ff;  // flash store strobe
	logic               unl_armed; // unlock pattern complete
	logic               fl_ok;     // flash store allowed

	// bus decode
	wire logic acc_wr  = bus_req.valid & bus_req.write;
	wire logic acc_rd  = bus_req.valid & ~bus_req.write;
	wire logic hit_ctl = (bus_req.addr == OFS_CONTROL);
	wire logic hit_unl = (bus_req.addr == OFS_UNLOCK);
	wire logic hit_alo = (bus_req.addr == OFS_ADDR_LO);
	wire logic hit_ahi = (bus_req.addr == OFS_ADDR_HI);
	wire logic hit_dlo = (bus_req.addr == OFS_DATA_LO);
	wire logic hit_dhi = (bus_req.addr == OFS_DATA_HI);
	wire logic hit_flg = (bus_req.addr == OFS_IRQ_FLG2);
	wire logic hit_ena = (bus_req.addr == OFS_IRQ_ENA2);
	wire logic hit_int = (bus_req.addr[6:0] == INT_LOW);
	wire logic [7:0] wd = bus_req.wdata;

	// operation status
	wire logic idle    = (op_ff == OP_IDLE);
	wire logic wr_busy = (op_ff == OP_WREE) | (op_ff == OP_WRFL);
	wire logic rd_busy = (op_ff == OP_RDEE) | (op_ff == OP_RDFL);
	wire logic fin     = ~idle & (cnt_ff == '0);
	wire logic wr_fin  = fin & wr_busy;
	wire logic upd     = acc_wr & idle;
	wire logic wr_ctl  = acc_wr & hit_ctl;
	wire logic pwrt_done = (pwrt_ff == PW_END);

	// the select bit travels with the go write
	wire logic sel_new = wd[B_MEMSEL];
	// target gate: flash by fuses, data by lockout only
	wire logic tgt_ok = sel_new ? fl_ok : pwrt_done;

	// go is taken only with old permit and a fresh unlock
	wire logic go_ok = wr_ctl & idle & wd[B_WGO]
		& permit_ff
		& unl_armed
		& tgt_ok;
	wire logic rd_ok = wr_ctl & idle & wd[B_RGO] & ~go_ok;

	// unlock tracker
	fnvwp_unlock u_unlock (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.bus_acc   (bus_req.valid),
		.port_wr   (acc_wr & hit_unl),
		.port_data (wd),
		.armed     (unl_armed)
	);

	// fuse latch and access permission
	fnvwp_guard #(
		.PROT_BASE (PROT_BASE)
	) u_guard (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.cfg_nv       (cfg_nv),
		.prog_load    (prog_load),
		.prog_word    (prog_word),
		.prog_erase   (prog_erase),
		.store_addr   ({ahi_ff, alo_ff}),
		.flash_ok     (fl_ok),
		.ext_read_ok  (ext_read_ok),
		.ext_write_ok (ext_write_ok)
	);

	// operation sequencer
	always_comb begin
		nxt_op  = op_ff;
		nxt_cnt = cnt_ff;
		case (op_ff)
			OP_IDLE: begin
				if (go_ok) begin
					// accepted store
					nxt_op  = sel_new ? OP_WRFL : OP_WREE;
					nxt_cnt = sel_new ? FL_LAST : EE_LAST;
				end else if (rd_ok) begin
					// accepted read
					nxt_op  = sel_new ? OP_RDFL : OP_RDEE;
					nxt_cnt = sel_new ? RF_LAST : '0;
				end
			end
			default: begin
				// only completion ends an operation
				if (fin) begin
					nxt_op = OP_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
		endcase
	end

	// sequencer state; a reset other than power-up mid-store leaves the abort flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op_ff  <= OP_IDLE;
			cnt_ff <= '0;
		end else begin
			op_ff  <= nxt_op;
			cnt_ff <= nxt_cnt;
		end
	end

	// control bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			permit_ff <= 1'b0;
			abort_ff  <= ~por_rst & (abort_ff | wr_busy);
			memsel_ff <= ~por_rst & memsel_ff;
		end else if (wr_ctl) begin
			permit_ff <= wd[B_PERMIT];
			abort_ff  <= wd[B_ABORT];
			// select frozen while busy
			memsel_ff <= idle ? wd[B_MEMSEL] : memsel_ff;
		end
	end

	// address and data; power-up clears, other resets keep
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			if (por_rst) begin
				alo_ff <= '0;
				ahi_ff <= '0;
				dlo_ff <= '0;
				dhi_ff <= '0;
			end
		end else begin
			// software loads, only while idle
			if (upd & hit_alo) begin
				alo_ff <= wd;
			end
			if (upd & hit_ahi) begin
				ahi_ff <= wd[AHI_W-1:0];
			end
			if (upd & hit_dlo) begin
				dlo_ff <= wd;
			end
			if (upd & hit_dhi) begin
				dhi_ff <= wd[DHI_W-1:0];
			end
			// read results land at completion
			if (fin & (op_ff == OP_RDEE)) begin
				dlo_ff <= ee_rdata;
			end
			if (fin & (op_ff == OP_RDFL)) begin
				dlo_ff <= fl_rdata[7:0];
				dhi_ff <= fl_rdata[WORD_W-1:8];
			end
		end
	end

	// done flag: completion wins over a software clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= wr_fin | ((acc_wr & hit_flg) ? wd[B_DONE] : done_ff);
		end
	end

	// masks
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dmask_ff <= 1'b0;
			gmask_ff <= 1'b0;
			pmask_ff <= 1'b0;
		end else begin
			if (acc_wr & hit_ena) begin
				dmask_ff <= wd[B_DONE];
			end
			if (acc_wr & hit_int) begin
				gmask_ff <= wd[B_GMASK];
				pmask_ff <= wd[B_PMASK];
			end
		end
	end

	// power-up lockout, restarted by power-on only
	always_ff @(posedge clk_sys) begin
		if (rst & por_rst) begin
			pwrt_ff <= '0;
		end else if (~pwrt_done) begin
			pwrt_ff <= pwrt_ff + 1'b1;
		end
	end

	// array store strobes, one cycle after go is taken
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ee_go_ff <= 1'b0;
			fl_go_ff <= 1'b0;
		end else begin
			ee_go_ff <= go_ok & ~sel_new;
			fl_go_ff <= go_ok & sel_new;
		end
	end

	// read mux; unlock port and unmapped read zero
	wire logic [7:0] ctl_rd = {memsel_ff, 3'h0, abort_ff, permit_ff,
		wr_busy, rd_busy};
	wire logic [7:0] rd_mux =
		hit_ctl ? ctl_rd :
		hit_alo ? alo_ff :
		hit_ahi ? {{(8-AHI_W){1'b0}}, ahi_ff} :
		hit_dlo ? dlo_ff :
		hit_dhi ? {{(8-DHI_W){1'b0}}, dhi_ff} :
		hit_flg ? {3'h0, done_ff, 4'h0} :
		hit_ena ? {3'h0, dmask_ff, 4'h0} :
		hit_int ? {gmask_ff, pmask_ff, 6'h00} :
		8'h00;

	// registered read answer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (acc_rd) begin
			rdata_ff <= rd_mux;
		end
	end

	// outputs
	assign bus_rdata = rdata_ff;
	// hold execution only; clocks and peripherals never gated
	assign core_stall = (op_ff == OP_WRFL) | (op_ff == OP_RDFL);
	// last stall cycle: drop the two held slots, go on at the third
	assign core_skip = fin & (op_ff == OP_WRFL);
	assign store_done_irq = done_ff & dmask_ff;
	assign arr_addr  = {ahi_ff, alo_ff};
	assign arr_wdata = {dhi_ff, dlo_ff};
	assign ee_store_go = ee_go_ff;
	assign fl_store_go = fl_go_ff;

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_fl_start;
		$rose(op_ff == OP_WRFL);
	endsequence

	sequence s_two_held;
		core_stall [*2];
	endsequence

	a_go_unlocked: assert property ($rose(wr_busy) |-> $past(unl_armed))
		else $error("store began without unlock");
	a_go_permit: assert property ($rose(wr_busy) |-> $past(permit_ff))
		else $error("store began without prior permit");
	a_flash_fuse: assert property (s_fl_start |-> $past(fl_ok))
		else $error("flash store despite guard");
	a_pwrt_lock: assert property ($rose(op_ff == OP_WREE) |-> $past(pwrt_done))
		else $error("data store during lockout");
	a_stall_two: assert property (s_fl_start |-> s_two_held)
		else $error("flash stall shorter than two");
	a_skip_end: assert property (core_skip |=> !core_stall && !wr_busy)
		else $error("stall outlived skip");
	a_done_set: assert property (wr_fin |=> done_ff && !wr_busy)
		else $error("completion missed done or go");
	a_go_held: assert property (wr_busy && !fin |=> wr_busy)
		else $error("go cleared before completion");
	a_strobe_go: assert property (go_ok && sel_new |=> fl_store_go)
		else $error("flash strobe missing");
endmodule : fnvwp_ctrl
`default_nettype wire

/* File: rtl/fnvwp_pkg.sv */
// fnvwp_pkg: constants and types for the nonvolatile write guard
package fnvwp_pkg;
	// clock and time figures
	localparam int CLK_NS      = 10;      // core clock period
	localparam int CLK_MHZ     = 100;     // core clock rate
	localparam int PWRT_MS     = 72;      // power-up lockout time
	localparam int FL_STORE_NS = 2000;    // flash store time, plain default
	localparam int EE_STORE_NS = 4000;    // data store time, plain default
	localparam int PWRT_CYC_DEF = PWRT_MS * 1000 * CLK_MHZ;
	localparam int FL_RAW = (FL_STORE_NS + CLK_NS - 1) / CLK_NS;
	localparam int FL_CYC_DEF = (FL_RAW < 2) ? 2 : FL_RAW; // two slots at least
	localparam int EE_RAW = (EE_STORE_NS + CLK_NS - 1) / CLK_NS;
	localparam int EE_CYC_DEF = (EE_RAW < 1) ? 1 : EE_RAW;
	localparam int RD_FL_CYC = 2;         // flash read stall slots
	localparam int CNT_W = 24;            // shared counter width
	// widths
	localparam int AHI_W  = 5;            // high address bits kept
	localparam int DHI_W  = 6;            // high data bits kept
	localparam int ADDR_W = 8 + AHI_W;    // flash word address
	localparam int WORD_W = 8 + DHI_W;    // flash word width
	localparam logic [ADDR_W-1:0] PROT_BASE_DEF = 13'h1000; // guarded half
	// register offsets
	localparam logic [8:0] OFS_INT_CTL  = 9'h00b; // mirrored in all banks
	localparam logic [6:0] INT_LOW      = 7'h0b;
	localparam logic [8:0] OFS_IRQ_FLG2 = 9'h00d;
	localparam logic [8:0] OFS_IRQ_ENA2 = 9'h08d;
	localparam logic [8:0] OFS_DATA_LO  = 9'h10c;
	localparam logic [8:0] OFS_ADDR_LO  = 9'h10d;
	localparam logic [8:0] OFS_DATA_HI  = 9'h10e;
	localparam logic [8:0] OFS_ADDR_HI  = 9'h10f;
	localparam logic [8:0] OFS_CONTROL  = 9'h18c;
	localparam logic [8:0] OFS_UNLOCK   = 9'h18d;
	// field positions
	localparam int B_MEMSEL = 7;
	localparam int B_ABORT  = 3;
	localparam int B_PERMIT = 2;
	localparam int B_WGO    = 1;
	localparam int B_RGO    = 0;
	localparam int B_DONE   = 4;
	localparam int B_GMASK  = 7;
	localparam int B_PMASK  = 6;
	// unlock pattern
	localparam logic [7:0] UNLOCK_1 = 8'h55;
	localparam logic [7:0] UNLOCK_2 = 8'haa;
	// core register access
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [8:0] addr;
		logic [7:0] wdata;
	} fnvwp_bus_type;
	// configuration fuses, zero means guarded or locked
	typedef struct packed {
		logic data_guard;
		logic guard_hi;
		logic guard_lo;
		logic store_permit;
	} fnvwp_cfg_type;
	localparam fnvwp_cfg_type CFG_ERASED = 4'hf;
	// operation in progress
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_RDEE = 3'b001,
		OP_RDFL = 3'b010,
		OP_WREE = 3'b011,
		OP_WRFL = 3'b100
	} fnvwp_op_type;
	// unlock tracking
	typedef enum logic [1:0] {
		UL_IDLE  = 2'b00,
		UL_GOT1  = 2'b01,
		UL_ARMED = 2'b10
	} fnvwp_unl_type;
endpackage : fnvwp_pkg

/* File: rtl/fnvwp_unlock.sv */
// fnvwp_unlock: tracks the two-step unlock pattern on the unlock port
`timescale 1ns/10ps
`default_nettype none
module fnvwp_unlock (
	input  wire logic       clk_sys,   // core clock
	input  wire logic       rst,       // synchronous reset
	input  wire logic       bus_acc,   // any register access
	input  wire logic       port_wr,   // write to unlock port
	input  wire logic [7:0] port_data, // byte written
	output logic            armed      // pattern just completed
);
	import fnvwp_pkg::*;

	fnvwp_unl_type st_ff;  // tracking state
	fnvwp_unl_type nxt_st; // next state

	wire logic step1 = port_wr & (port_data == UNLOCK_1);
	wire logic step2 = port_wr & (port_data == UNLOCK_2);

	// any access that is not the next step starts over
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			UL_GOT1: begin
				if (bus_acc) begin
					nxt_st = step2 ? UL_ARMED : (step1 ? UL_GOT1 : UL_IDLE);
				end
			end
			default: begin
				if (bus_acc) begin
					nxt_st = step1 ? UL_GOT1 : UL_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_ff <= UL_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign armed = (st_ff == UL_ARMED);

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_pair;
		step1 ##1 step2;
	endsequence

	// pattern with one idle cycle between the two steps
	sequence s_pair_gap;
		step1 ##1 !bus_acc ##1 step2;
	endsequence

	a_arm_order: assert property (s_pair |=> armed)
		else $error("unlock pair did not arm");
	a_break_reset: assert property (armed && bus_acc |=> !armed)
		else $error("arm survived an access");
	a_arm_gap: assert property (s_pair_gap |=> armed)
		else $error("spaced unlock pair did not arm");
endmodule : fnvwp_unlock
`default_nettype wire

/* File: rtl/fnvwp_guard.sv */
// fnvwp_guard: configuration fuse latch and access permissions
`timescale 1ns/10ps
`default_nettype none
module fnvwp_guard #(
	parameter logic [fnvwp_pkg::ADDR_W-1:0] PROT_BASE = fnvwp_pkg::PROT_BASE_DEF
) (
	input  wire logic                          clk_sys,      // core clock
	input  wire logic                          rst,          // synchronous reset
	input  wire fnvwp_pkg::fnvwp_cfg_type      cfg_nv,       // stored fuse cells
	input  wire logic                          prog_load,    // programmer fuse write
	input  wire fnvwp_pkg::fnvwp_cfg_type      prog_word,    // fuse word to write
	input  wire logic                          prog_erase,   // programmer bulk erase
	input  wire logic [fnvwp_pkg::ADDR_W-1:0]  store_addr,   // target flash word
	output logic                               flash_ok,     // internal flash store allowed
	output logic                               ext_read_ok,  // programmer read allowed
	output logic                               ext_write_ok  // programmer write allowed
);
	import fnvwp_pkg::*;

	fnvwp_cfg_type cfg_ff; // active fuse word

	// only the programmer touches fuses; writes clear bits, erase sets all
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_ff <= cfg_nv;
		end else if (prog_erase) begin
			cfg_ff <= CFG_ERASED;
		end else if (prog_load) begin
			cfg_ff <= cfg_ff & prog_word;
		end
	end

	wire logic full_open = cfg_ff.guard_hi & cfg_ff.guard_lo;
	wire logic partial   = cfg_ff.guard_hi ^ cfg_ff.guard_lo;
	wire logic in_guard  = partial & (store_addr >= PROT_BASE);

	// internal stores follow the permit fuse, partial guard blocks a segment
	assign flash_ok = cfg_ff.store_permit & ~in_guard;
	// any guard, data guard included, shuts the programmer out
	assign ext_read_ok  = full_open & cfg_ff.data_guard;
	assign ext_write_ok = full_open & cfg_ff.data_guard;

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_ext_lock: assert property (!cfg_ff.data_guard |-> !ext_read_ok && !ext_write_ok)
		else $error("programmer open under data guard");
	a_fuse_gate: assert property (!cfg_ff.store_permit |-> !flash_ok)
		else $error("flash store open with fuse clear");
	a_fuse_sticky: assert property (!prog_erase && !cfg_ff.store_permit |=> !cfg_ff.store_permit)
		else $error("fuse cleared without erase");
endmodule : fnvwp_guard
`default_nettype wire

/* File: testbench/fnvwp_array_model.sv */
// fnvwp_array_model: behavioural data and flash arrays behind the store strobes
`timescale 1ns/10ps
`default_nettype none
module fnvwp_array_model (
	input  wire logic                         clk_sys,     // core clock
	input  wire logic [fnvwp_pkg::ADDR_W-1:0] arr_addr,    // word or byte address
	input  wire logic [fnvwp_pkg::WORD_W-1:0] arr_wdata,   // value to store
	input  wire logic                         ee_store_go, // data store strobe
	input  wire logic                         fl_store_go, // flash store strobe
	output logic      [7:0]                   ee_rdata,    // data array read
	output logic      [fnvwp_pkg::WORD_W-1:0] fl_rdata     // flash read
);
	import fnvwp_pkg::*;
	logic [7:0]        ee_mem [256];  // data cells
	logic [WORD_W-1:0] fl_mem [8192]; // flash words
	// cells start with an address pattern, never unknown
	initial begin
		for (int i = 0; i < 8192; i++) begin
			fl_mem[i] = WORD_W'(i ^ 'h1555);
			if (i < 256) begin
				ee_mem[i] = 8'(i ^ 'h5a);
			end
		end
	end
	// stores land on the strobe edge
	always @(posedge clk_sys) begin
		if (ee_store_go === 1'b1) begin
			ee_mem[arr_addr[7:0]] <= arr_wdata[7:0];
		end
		if (fl_store_go === 1'b1) begin
			fl_mem[arr_addr] <= arr_wdata;
		end
	end
	// reads follow the address at once
	assign ee_rdata = ee_mem[arr_addr[7:0]];
	assign fl_rdata = fl_mem[arr_addr];
endmodule : fnvwp_array_model
`default_nettype wire

/* File: testbench/flash_eeprom_write_protect_ctrl_bench.sv */
// flash_eeprom_write_protect_ctrl_bench: register-level test of the write guard
`timescale 1ns/10ps
`default_nettype none
module flash_eeprom_write_protect_ctrl_bench;
	import fnvwp_pkg::*;
	localparam int FLC = 4; // flash stall cycles in sim
	logic          clk_sys, rst, por_rst, prog_load, prog_erase;
	fnvwp_cfg_type cfg_nv, prog_word;
	fnvwp_bus_type bus_req;
	logic [7:0]        bus_rdata, ee_rdata;
	logic              core_stall, core_skip, store_done_irq, ee_store_go, fl_store_go;
	logic [ADDR_W-1:0] arr_addr;
	logic [WORD_W-1:0] arr_wdata, fl_rdata;
	logic              ext_read_ok, ext_write_ok;
	int                err_count, cmp_count, n_stall, n_skip, n_fl, n_ee;
	fnvwp_ctrl #(.PWRT_CYC(20), .FL_CYC(FLC), .EE_CYC(3), .PROT_BASE(13'h1000)) dut (
		.clk_sys(clk_sys), .rst(rst), .por_rst(por_rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .core_stall(core_stall), .core_skip(core_skip),
		.store_done_irq(store_done_irq), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.ee_store_go(ee_store_go), .fl_store_go(fl_store_go), .ee_rdata(ee_rdata),
		.fl_rdata(fl_rdata), .cfg_nv(cfg_nv), .prog_load(prog_load), .prog_word(prog_word),
		.prog_erase(prog_erase), .ext_read_ok(ext_read_ok), .ext_write_ok(ext_write_ok));
	fnvwp_array_model u_arr (
		.clk_sys(clk_sys), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.ee_store_go(ee_store_go), .fl_store_go(fl_store_go),
		.ee_rdata(ee_rdata), .fl_rdata(fl_rdata));
	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// event counters, skip only counts inside a stall
	always @(posedge clk_sys) begin
		if (core_stall === 1'b1) n_stall++;
		if (core_skip === 1'b1 && core_stall === 1'b1) n_skip++;
		if (fl_store_go === 1'b1) n_fl++;
		if (ee_store_go === 1'b1) n_ee++;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// one bus access, held over one taking edge, then an idle cycle
	task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
		bus_req = '{1'b1, w, a, d};
		@(posedge clk_sys);
		@(negedge clk_sys);
		bus_req.valid = 1'b0;
		@(negedge clk_sys);
	endtask : acc
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		check(16'(bus_rdata), 16'(exp));
	endtask : rd
	// reset with fuse cells, then unmask the done flag
	task automatic rs(input fnvwp_cfg_type c, input logic p);
		rst = 1'b1;
		por_rst = p;
		cfg_nv = c;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		por_rst = 1'b0;
		n_stall = 0; n_skip = 0; n_fl = 0; n_ee = 0;
		acc(1'b1, 9'h08d, 8'h10);
	endtask : rs
	// permit, unlock pair, then go with the select bit
	task automatic arm(input logic sel);
		acc(1'b1, 9'h18c, {sel, 7'h04});
		acc(1'b1, 9'h18d, 8'h55);
		acc(1'b1, 9'h18d, 8'haa);
		acc(1'b1, 9'h18c, {sel, 7'h06});
	endtask : arm
	task automatic go(input logic sel, input logic [12:0] a, input logic [13:0] d);
		acc(1'b1, 9'h10f, {3'h0, a[12:8]});
		acc(1'b1, 9'h10d, a[7:0]);
		acc(1'b1, 9'h10e, {2'h0, d[13:8]});
		acc(1'b1, 9'h10c, d[7:0]);
		arm(sel);
	endtask : go
	// bounded wait for done, then strobe and stall counts
	task automatic wt(input logic sel, input logic ok);
		int i;
		for (i = 0; i < 40 && store_done_irq !== 1'b1; i++) @(negedge clk_sys);
		if (ok && i == 40) begin
			err_count++;
			wrap_up();
		end
		check(16'(store_done_irq), 16'(ok));
		check(16'(sel ? n_fl : n_ee), 16'(ok));
		check(16'(n_stall), (sel && ok) ? 16'(FLC) : 16'h0);
		check(16'(n_skip), 16'(sel && ok));
		acc(1'b1, 9'h00d, 8'h00);
		rd(9'h00d, 8'h00);
		n_stall = 0; n_skip = 0; n_fl = 0; n_ee = 0;
	endtask : wt
	task automatic pg(input logic e, input fnvwp_cfg_type w);
		prog_word = w;
		prog_load = ~e;
		prog_erase = e;
		@(negedge clk_sys);
		prog_load = 1'b0;
		prog_erase = 1'b0;
		@(negedge clk_sys);
	endtask : pg
	// hang guard
	initial begin
		repeat (50000) @(posedge clk_sys);
		err_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		prog_load = 1'b0;
		prog_erase = 1'b0; prog_word = 4'hf; bus_req = '0;
		err_count = 0; cmp_count = 0;
		rs(4'b0111, 1'b1);
		check(16'(ext_read_ok), 16'h0);
		rd(9'h18c, 8'h00);
		rd(9'h18d, 8'h00);
		rd(9'h1ff, 8'h00);
		arm(1'b0);
		wt(1'b0, 1'b0);
		go(1'b0, 13'h0005, 14'h00a5);
		wt(1'b0, 1'b1);
		check(16'(u_arr.ee_mem[5]), 16'h00a5);
		acc(1'b1, 9'h10d, 8'h06);
		acc(1'b1, 9'h18c, 8'h01);
		rd(9'h10c, 8'h5c);
		acc(1'b1, 9'h18c, 8'h00);
		acc(1'b1, 9'h18d, 8'h55);
		acc(1'b1, 9'h18d, 8'haa);
		acc(1'b1, 9'h18c, 8'h06);
		wt(1'b0, 1'b0);
		acc(1'b1, 9'h18c, 8'h04);
		acc(1'b1, 9'h18d, 8'h55);
		rd(9'h10d, 8'h06);
		acc(1'b1, 9'h18d, 8'haa);
		acc(1'b1, 9'h18c, 8'h06);
		wt(1'b0, 1'b0);
		go(1'b1, 13'h0123, 14'h2bcd);
		wt(1'b1, 1'b1);
		rd(9'h18c, 8'h84);
		check(16'(u_arr.fl_mem[13'h0123]), 16'h2bcd);
		acc(1'b1, 9'h10c, 8'h00);
		acc(1'b1, 9'h18c, 8'h85);
		repeat (4) @(negedge clk_sys);
		rd(9'h10c, 8'hcd);
		rd(9'h10e, 8'h2b);
		go(1'b0, 13'h0044, 14'h0011);
		rs(4'b0111, 1'b0);
		rd(9'h18c, 8'h08);
		rd(9'h10d, 8'h44);
		rs(4'b1010, 1'b0);
		go(1'b1, 13'h0010, 14'h0001);
		wt(1'b1, 1'b0);
		check(16'(ext_write_ok), 16'h0);
		rs(4'b1101, 1'b0);
		go(1'b1, 13'h1000, 14'h0001);
		wt(1'b1, 1'b0);
		go(1'b1, 13'h0fff, 14'h0abc);
		wt(1'b1, 1'b1);
		rs(4'hf, 1'b0);
		acc(1'b1, 9'h18c, 8'hff);
		check(16'({ext_read_ok, ext_write_ok}), 16'h3);
		pg(1'b0, 4'b1011);
		check(16'(ext_read_ok), 16'h0);
		pg(1'b0, 4'hf);
		check(16'(ext_read_ok), 16'h0);
		pg(1'b1, 4'h0);
		check(16'({ext_read_ok, ext_write_ok}), 16'h3);
		pg(1'b0, 4'b1001);
		check(16'({ext_read_ok, ext_write_ok}), 16'h0);
		wrap_up();
	end
endmodule : flash_eeprom_write_protect_ctrl_bench
`default_nettype wire
